// >>> rtl/scan_tap_pkg.sv
// Purpose: shared constants and types of the boundary-scan test port
// Assumes: tck, tms and tdi are sampled by ref_clk through two-flop synchronisers
// Notes: instruction codes, register widths and capture values live here
package scan_tap_pkg;

  // instruction register width and codes
  localparam int IR_W = 3;
  localparam logic [2:0] IR_BYPASS0 = 3'h0;
  localparam logic [2:0] IR_IDENT = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_BYPASS3 = 3'h3;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_PRIVATE = 3'h5;
  localparam logic [2:0] IR_BYPASS6 = 3'h6;
  localparam logic [2:0] IR_BYPASS7 = 3'h7;
  // reset value of the instruction register
  localparam logic [2:0] IR_RESET = IR_IDENT;
  // identification register width and fixed start bit
  localparam int ID_W = 32;
  localparam int ID_START_POS = 0;
  // default boundary length
  localparam int BSR_W_DEF = 70;
  // bypass capture value
  localparam logic BYP_CAPTURE = 1'b0;
  // bit pattern captured into all three instruction bits in capture-ir
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // synchroniser depth
  localparam int SYNC_STAGES = 2;

  // controller states
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PAU_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } tap_state_t;

  // bypass codes are everything but ident, sample modes and private
  function automatic logic is_bypass(input logic [2:0] code);
    is_bypass = (code == IR_BYPASS0) || (code == IR_BYPASS3) ||
                (code == IR_BYPASS6) || (code == IR_BYPASS7);
  endfunction

  // boundary register selected by either sample code
  function automatic logic is_sample(input logic [2:0] code);
    is_sample = (code == IR_SAMPLE) || (code == IR_SAMPLE_Z);
  endfunction

endpackage

// >>> rtl/scan_sync.sv
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: inputs are levels from outside the ref_clk domain
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module scan_sync
  import scan_tap_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r; // first stage
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  // next values, held while the enable is low
  always_comb begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_out;
  end

  // register both stages
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end

endmodule

// >>> rtl/sram_boundary_scan_tap.sv
// Purpose: boundary-scan test port of a synchronous memory, run on sampled tck
// Assumes: tck far slower than ref_clk; pins arrive asynchronous to ref_clk
// Notes: the memory data path is outside; only its output-enable gate is here
//
// Behaviour
// RQ1: controller plus instruction, ident, bypass, boundary registers
// RQ2: controller advances only on test clock rising edges
// RQ3: mode select sampled at each test clock rise
// RQ4: test data sampled into register at rising edge
// RQ5: test output updates at falling test clock edge
// RQ6: high-z sampling forces memory outputs off
// RQ7: otherwise memory traffic passes untouched
// RQ8: unused port: clock low, inputs tied
// RQ9: three-bit instruction decoded to bypass, ident, samples
// RQ10: ident loaded at reset, capture-ir; applied at update-ir
// RQ11: bypass bit captures zero, shifts in shift-dr
// RQ12: 32-bit ident, lsb one, shifts msb in lsb out
// RQ13: sixteen-state sequence, five highs reach reset
`timescale 1ns/1ps
module sram_boundary_scan_tap
  import scan_tap_pkg::*;
#(
  parameter int BSR_W = BSR_W_DEF,
  parameter logic [3:0] REV_CODE = 4'h0, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234, // arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h155 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [BSR_W-1:0] io_ring,
  input wire logic mem_dq_oe_req,
  output logic tdo,
  output logic tdo_oe,
  output logic mem_dq_oe,
  output logic highz_active
);

  // ident value with fixed start bit of one
  localparam logic [ID_W-1:0] ID_VALUE = {REV_CODE, PART_CODE, MAKER_CODE, 1'b1};

  logic tck_s; // synchronised pins
  logic tms_s;
  logic tdi_s;
  logic tck_d_r; // previous tck sample for edge finding
  logic tck_d_nxt;
  logic rise; // rising and falling test clock edge
  logic fall;

  tap_state_t state_r; // controller state
  tap_state_t state_nxt;
  logic [IR_W-1:0] ir_sh_r; // instruction shift stage
  logic [IR_W-1:0] ir_sh_nxt;
  logic [IR_W-1:0] ir_r; // current instruction
  logic [IR_W-1:0] ir_nxt;
  logic [ID_W-1:0] id_r; // identification shift
  logic [ID_W-1:0] id_nxt;
  logic byp_r; // bypass bit
  logic byp_nxt;
  logic [BSR_W-1:0] bsr_r; // boundary shift
  logic [BSR_W-1:0] bsr_nxt;
  logic tdo_nxt;
  logic tdo_oe_nxt;
  logic dq_oe_nxt;
  logic hz_nxt;
  logic serial_bit; // bit facing the output, picked by state and code

  // sample the asynchronous test pins; tms/tdi stable around tck rise, RQ8 relied on
  scan_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .async_in({tck, tms, tdi}),
    .sync_out({tck_s, tms_s, tdi_s})
  );

  // edge finding on the synchronised test clock
  always_comb begin
    tck_d_nxt = clk_en ? tck_s : tck_d_r;
    rise = clk_en && tck_s && !tck_d_r;
    fall = clk_en && !tck_s && tck_d_r;
  end

  // controller next state, moved only by test clock rises
  always_comb begin
    state_nxt = state_r;
    if (rise) begin // RQ2
      case (state_r) // RQ13 RQ3
        ST_RESET: state_nxt = tms_s ? ST_RESET : ST_IDLE;
        ST_IDLE: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: state_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: state_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: state_nxt = tms_s ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: state_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: state_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: state_nxt = tms_s ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
        default: state_nxt = ST_RESET;
      endcase
    end
  end

  // test registers: capture and shift on rise, ir applied at update-ir
  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    id_nxt = id_r;
    byp_nxt = byp_r;
    bsr_nxt = bsr_r;
    if (rise) begin
      case (state_r)
        ST_CAP_IR: ir_sh_nxt = IR_CAPTURE; // RQ10
        ST_SH_IR: ir_sh_nxt = {tdi_s, ir_sh_r[IR_W-1:1]}; // RQ4
        ST_CAP_DR: begin
          // RQ1 RQ9
          if (ir_r == IR_IDENT) begin
            id_nxt = ID_VALUE; // RQ12
          end else if (is_sample(ir_r)) begin
            bsr_nxt = io_ring;
          end else if (is_bypass(ir_r)) begin
            byp_nxt = BYP_CAPTURE; // RQ11
          end
        end
        ST_SH_DR: begin
          // RQ4
          if (ir_r == IR_IDENT) begin
            id_nxt = {tdi_s, id_r[ID_W-1:1]}; // RQ12
          end else if (is_sample(ir_r)) begin
            bsr_nxt = {tdi_s, bsr_r[BSR_W-1:1]};
          end else begin
            byp_nxt = tdi_s; // RQ11
          end
        end
        default: begin
          // hold in every other state
        end
      endcase
    end
    // the new instruction becomes current on leaving update-ir
    if (rise && state_r == ST_UPD_IR) begin
      ir_nxt = ir_sh_r; // RQ10
    end
    // the rise that enters test-logic-reset restores ident at once,
    // so a five-high walk from shift-dr never leaves a stale code
    if (rise && state_nxt == ST_RESET) begin
      ir_nxt = IR_RESET; // RQ10 RQ13
      ir_sh_nxt = IR_RESET;
    end
  end

  // output bit: ir while in shift-ir, else the selected data register
  always_comb begin
    if (state_r == ST_SH_IR) begin
      serial_bit = ir_sh_r[0];
    end else if (ir_r == IR_IDENT) begin
      serial_bit = id_r[0];
    end else if (is_sample(ir_r)) begin
      serial_bit = bsr_r[0];
    end else begin
      serial_bit = byp_r; // private code also falls here
    end
  end

  // tdo and tdo_oe, updated on the falling test clock edge
  always_comb begin
    tdo_nxt = tdo;
    tdo_oe_nxt = tdo_oe;
    if (fall) begin // RQ5
      tdo_oe_nxt = (state_r == ST_SH_IR) || (state_r == ST_SH_DR);
      // line parked low outside shifting
      tdo_nxt = tdo_oe_nxt ? serial_bit : 1'b0;
    end
    // high-z sampling gates the memory drivers, else pass request through
    hz_nxt = (ir_r == IR_SAMPLE_Z); // RQ6
    dq_oe_nxt = clk_en ? (mem_dq_oe_req && !hz_nxt) : mem_dq_oe; // RQ6 RQ7
    hz_nxt = clk_en ? hz_nxt : highz_active;
  end

  // register all state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_d_r <= 1'b0;
      state_r <= ST_RESET;
      ir_sh_r <= IR_RESET;
      ir_r <= IR_RESET;
      id_r <= '0;
      byp_r <= 1'b0;
      bsr_r <= '0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      mem_dq_oe <= 1'b0;
      highz_active <= 1'b0;
    end else begin
      tck_d_r <= tck_d_nxt;
      state_r <= state_nxt;
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      id_r <= id_nxt;
      byp_r <= byp_nxt;
      bsr_r <= bsr_nxt;
      tdo <= tdo_nxt;
      tdo_oe <= tdo_oe_nxt;
      mem_dq_oe <= dq_oe_nxt;
      highz_active <= hz_nxt;
    end
  end

endmodule

// >>> testbench/scan_tap_checker.sv
// Purpose: port checks of the scan test port
// Assumes: each tck phase lasts several ref_clk cycles
// Notes: bound into the top module below
`timescale 1ns/1ps
module scan_tap_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic mem_dq_oe_req,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic mem_dq_oe,
  input wire logic highz_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // test clock held at one level
  sequence tck_high4; tck [*4]; endsequence
  sequence tck_low4; (!tck) [*4]; endsequence
  // out of reset for two samples
  sequence live; $past(arst_n) [*2]; endsequence
  AST_DQ_OFF: assert property (live ##0 highz_active && $past(highz_active) |-> !mem_dq_oe)
    else $error("data drivers on during high-z sampling");
  AST_DQ_PASS: assert property (live ##0 !highz_active && !$past(highz_active)
    |-> mem_dq_oe == $past(mem_dq_oe_req))
    else $error("data driver enable not passed through");
  AST_TDO_FALL: assert property (live ##0 $changed(tdo) |-> !$past(tck))
    else $error("tdo moved outside a tck fall");
  AST_OE_FALL: assert property (live ##0 $changed(tdo_oe) |-> !$past(tck))
    else $error("tdo_oe moved outside a tck fall");
  AST_IR_RISE: assert property (live ##0 $changed(highz_active) |-> $past(tck))
    else $error("instruction changed outside a tck rise");
  AST_TDO_HOLD: assert property (tck_high4 |-> $stable(tdo) && $stable(tdo_oe))
    else $error("tdo changed while tck high");
  AST_IR_HOLD: assert property (tck_low4 |-> $stable(highz_active))
    else $error("instruction changed while tck low");
  AST_TDO_IDLE: assert property ((!tdo_oe) [*2] |-> !tdo)
    else $error("tdo not low outside shifting");
  AST_RESET_OUT: assert property ($rose(arst_n) |-> !highz_active && !tdo_oe && !mem_dq_oe)
    else $error("outputs not cleared by reset");
endmodule
bind sram_boundary_scan_tap scan_tap_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .tck(tck), .mem_dq_oe_req(mem_dq_oe_req), .tdo(tdo), .tdo_oe(tdo_oe),
  .mem_dq_oe(mem_dq_oe), .highz_active(highz_active));

// >>> testbench/jtag_host.sv
// Purpose: model of the external scan controller
// Assumes: 170 ns tck, 9 ref_clk cycles low and 8 high
// Notes: tck rests low between calls
`timescale 1ns/1ps
module jtag_host (
  input wire logic ref_clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // defined levels from time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period; tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge ref_clk);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge ref_clk);
    q = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge ref_clk);
    tck <= 1'b0;
  endtask
endmodule

// >>> testbench/sram_boundary_scan_tap_test.sv
// Purpose: self-checking bench of the scan test port
// Assumes: tdo line pulled up while undriven
// Notes: ident fields given arbitrary values here
`timescale 1ns/1ps
module sram_boundary_scan_tap_test;
  import scan_tap_pkg::*;
  localparam logic [31:0] ID = {4'ha, 16'h0bcd, 11'h2a5, 1'b1}; // arbitrary value
  localparam logic [69:0] RING = {6'h2d, 64'h5a5a_c3c3_0ff0_1234};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req = 1'b1;
  logic en = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, dq_oe, hz;
  logic [69:0] got;
  int bad_count = 0;
  int n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  jtag_host u_host (.ref_clk(ref_clk), .tdo(tdo_oe ? tdo : 1'b1), .tck(tck), .tms(tms),
    .tdi(tdi));
  sram_boundary_scan_tap #(.REV_CODE(ID[31:28]), .PART_CODE(ID[27:12]),
    .MAKER_CODE(ID[11:1])) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(en),
    .tck(tck), .tms(tms), .tdi(tdi), .io_ring(RING), .mem_dq_oe_req(req), .tdo(tdo),
    .tdo_oe(tdo_oe), .mem_dq_oe(dq_oe), .highz_active(hz));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [69:0] exp, input logic [69:0] seen);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // tms walk, first bit in bit 0
  task automatic walk(input logic [7:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++) u_host.step(pat[i], 1'b0, q);
  endtask
  task automatic ir_load(input logic [2:0] c);
    logic q;
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) u_host.step(i == 2, c[i], q);
    walk(8'h01, 2);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic dr_scan(input int n, input logic [69:0] din);
    logic q;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      u_host.step(i == n - 1, din[i], q);
      got[i] = q;
    end
    walk(8'h01, 2);
  endtask
  task automatic t_ident();
    got = '0;
    dr_scan(32, 70'h0);
    chk("ident", {38'h0, ID}, got);
    $display("test ident done");
  endtask
  task automatic t_bypass();
    logic [2:0] codes [4] = '{IR_BYPASS0, IR_BYPASS3, IR_BYPASS6, IR_BYPASS7};
    foreach (codes[k]) begin
      ir_load(codes[k]);
      got = '0;
      dr_scan(4, 70'hb);
      chk("bypass", 70'h6, got);
    end
    ir_load(IR_PRIVATE);
    got = '0;
    dr_scan(4, 70'hb);
    chk("private shift", 70'h3, got >> 1);
    chk("private highz", 1'b0, hz);
    $display("test bypass done");
  endtask
  task automatic t_sample(input logic [2:0] c, input logic z);
    ir_load(c);
    chk("highz", z, hz);
    chk("dq_oe", !z, dq_oe);
    req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("dq_oe off", 1'b0, dq_oe);
    req <= 1'b1;
    dr_scan(70, 70'h0);
    chk("ring", RING, got);
    chk("dq_oe on", !z, dq_oe);
    $display("test sample done");
  endtask
  task automatic t_reset5();
    walk(8'h1f, 5);
    repeat (4) @(posedge ref_clk);
    chk("highz off", 1'b0, hz);
    chk("dq_oe back", 1'b1, dq_oe);
    walk(8'h00, 1);
    t_ident();
    $display("test reset5 done");
  endtask
  // a whole instruction load with the enable low must leave no trace
  task automatic t_freeze();
    en <= 1'b0;
    ir_load(IR_SAMPLE_Z);
    en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("frozen highz", 1'b0, hz);
    chk("frozen dq_oe", 1'b1, dq_oe);
    ir_load(IR_SAMPLE_Z);
    chk("thawed highz", 1'b1, hz);
    $display("test freeze done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    walk(8'h00, 1);
    t_ident();
    t_bypass();
    t_sample(IR_SAMPLE, 1'b0);
    t_sample(IR_SAMPLE_Z, 1'b1);
    t_reset5();
    t_freeze();
    ir_load(IR_IDENT);
    t_ident();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end
endmodule
